// ===== tb/boc_ctrl_asserts.sv
`timescale 1ns/1ps
module boc_ctrl_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic overcurrent_cmp,
	input wire logic high_drive,
	input wire logic low_drive,
	input wire logic [7:0] softstart_capacitor,
	input wire logic [7:0] reg_reference,
	input wire logic undervoltage_lockout,
	input wire logic hiccup_active,
	input wire logic [2:0] fault_count
);
	// ------------------------------------------
	// Checks
	// ------------------------------------------
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic [7:0] lift;
	assign lift = softstart_capacitor - boc_pkg::SS_OFFSET;
	sequence oc_hit;
		$rose(overcurrent_cmp) && high_drive;
	endsequence
	sequence out_two;
		undervoltage_lockout ##1 undervoltage_lockout;
	endsequence
	chk_oc_cut:
		assert property (oc_hit |-> ##[1:4] !high_drive)
		else $error("pulse not cut");
	chk_hiccup_off:
		assert property (hiccup_active |-> !high_drive && !low_drive)
		else $error("drive in hiccup");
	chk_lockout_off:
		assert property (undervoltage_lockout |-> !high_drive && !low_drive)
		else $error("drive in lockout");
	chk_fault_clear:
		assert property (out_two |-> fault_count == 3'h0)
		else $error("count kept in lockout");
	chk_fault_step:
		assert property (!undervoltage_lockout && $changed(fault_count) |->
			(int'(fault_count) - int'($past(fault_count))) inside {1, -1})
		else $error("count jumped");
	chk_hiccup_entry:
		assert property ($rose(hiccup_active) |-> fault_count == 3'h7)
		else $error("hiccup below seven");
	chk_hiccup_exit:
		assert property ($fell(hiccup_active) && !undervoltage_lockout |->
			fault_count == 3'h0)
		else $error("hiccup left early");
	chk_ref_track:
		assert property (reg_reference == (softstart_capacitor <
			boc_pkg::SS_OFFSET ? 8'h00 : lift < boc_pkg::REF_LEVEL ? lift :
			boc_pkg::REF_LEVEL))
		else $error("reference wrong");
endmodule
bind boc_ctrl boc_ctrl_asserts chk (.sys_clk, .rst_n, .overcurrent_cmp,
	.high_drive, .low_drive, .softstart_capacitor, .reg_reference,
	.undervoltage_lockout, .hiccup_active, .fault_count);

// ===== tb/boc_ctrl_bench.sv
`timescale 1ns/1ps
module boc_ctrl_bench;
	logic sys_clk = 1'b0, rst_n = 1'b0, osc_tick = 1'b0, ramp_done = 1'b1;
	logic pwm_compare = 1'b0, short_on = 1'b0, sync_on = 1'b0;
	logic sync_in, overcurrent_cmp, high_drive, low_drive, sync_locked;
	logic undervoltage_lockout, hiccup_active;
	logic [7:0] softstart_capacitor, reg_reference;
	logic [2:0] fault_count;
	logic [31:0] seed = 32'h17f7;
	int miscompares = 0, comparisons = 0, cyc = 0, ocnt = 0;
	// ------------------------------------------
	// Harness
	// ------------------------------------------
	always #10 sys_clk = ~sys_clk;
	boc_ctrl #(.SYNC_TIMEOUT(16)) uut (.sys_clk, .rst_n, .osc_tick,
		.sync_in, .ramp_done, .pwm_compare, .overcurrent_cmp, .high_drive,
		.low_drive, .softstart_capacitor, .reg_reference,
		.undervoltage_lockout, .hiccup_active, .fault_count, .sync_locked);
	boc_fet_model fets (.sys_clk, .high_drive, .short_on, .sync_on,
		.overcurrent_cmp, .sync_in);
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] ref_of(input logic [7:0] ss);
		if (ss < boc_pkg::SS_OFFSET) return 8'h00;
		if (ss - boc_pkg::SS_OFFSET < boc_pkg::REF_LEVEL) begin
			return ss - boc_pkg::SS_OFFSET;
		end
		return boc_pkg::REF_LEVEL;
	endfunction
	// The sync source runs a quarter faster than this oscillator.
	always @(negedge sys_clk) begin
		ocnt <= (ocnt + 1) % 10;
		osc_tick <= ocnt < 5;
		pwm_compare <= ^xs();
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_on(ref logic sig, input logic val);
		int n = 0;
		while (sig !== val && n < 40000) begin
			@(negedge sys_clk);
			n++;
		end
		if (sig !== val) begin
			miscompares++;
		end
	endtask
	task close_out();
		$display("compares %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		chk({high_drive, low_drive}, 2'b00);
		chk(fault_count, 3'h0);
		rst_n = 1'b1;
		wait_on(undervoltage_lockout, 1'b0);
		chk(undervoltage_lockout, 1'b0);
		chk(sync_locked, 1'b0);
		$display("startup test done");
		short_on = 1'b1;
		wait_on(hiccup_active, 1'b1);
		chk(fault_count, 3'h7);
		repeat (30) begin
			repeat (90) @(negedge sys_clk);
			chk(reg_reference, ref_of(softstart_capacitor));
			chk({high_drive, low_drive}, 2'b00);
		end
		wait_on(hiccup_active, 1'b0);
		chk(fault_count, 3'h0);
		wait_on(hiccup_active, 1'b1);
		chk(fault_count, 3'h7);
		short_on = 1'b0;
		wait_on(hiccup_active, 1'b0);
		chk(fault_count, 3'h0);
		$display("overcurrent test done");
		sync_on = 1'b1;
		wait_on(sync_locked, 1'b1);
		chk(sync_locked, 1'b1);
		ramp_done = 1'b0;
		wait_on(undervoltage_lockout, 1'b1);
		chk(undervoltage_lockout, 1'b1);
		@(negedge sys_clk);
		chk(fault_count, 3'h0);
		sync_on = 1'b0;
		ramp_done = 1'b1;
		repeat (40) @(negedge sys_clk);
		chk(sync_locked, 1'b0);
		wait_on(undervoltage_lockout, 1'b0);
		chk(undervoltage_lockout, 1'b0);
		$display("sync test done");
		close_out();
	end
endmodule

// ===== tb/boc_fet_model.sv
`timescale 1ns/1ps
module boc_fet_model #(
	parameter int SYNC_PER = 8
) (
	input wire logic sys_clk,
	input wire logic high_drive,
	input wire logic short_on,
	input wire logic sync_on,
	output logic overcurrent_cmp = 1'b0,
	output logic sync_in = 1'b0
);
	// ------------------------------------------
	// Switch pair and sync source
	// ------------------------------------------
	int cnt = 0;
	// The drop is only sensed while the high side conducts.
	always @(negedge sys_clk) begin
		overcurrent_cmp <= short_on && high_drive;
		cnt <= (cnt + 1) % SYNC_PER;
		sync_in <= sync_on && (cnt < SYNC_PER / 2);
	end
endmodule

// ===== verilog/boc_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Overcurrent while high side is on ends the pulse one clock after the synchronised comparator.
// - After an overcurrent cut, high side stays off until next cycle.
// - Fault count rises per overcurrent cycle, falls per clean cycle.
// - Count of seven starts hiccup: restart plus seven soft-starts.
// - Both switch drives are held off for the whole hiccup.
// - Hiccup decrements count per soft-start; zero re-enables PWM.
// - Persistent overcurrent reaccumulates seven and re-enters hiccup.
// - Switching cycle aligns to the falling edge of sync input.
// - A present sync clock replaces the internal oscillator.
// - Sync held low means free-running on the internal oscillator.
// - Sync arriving before ramp end declares undervoltage lockout.
// - Reference is lower of soft-start minus offset or fixed reference.
// - Lockout uses 3-bit count: seven good releases, seven bad trips.
module boc_ctrl #(
	parameter int SYNC_TIMEOUT = 64
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic osc_tick,
	input wire logic sync_in,
	input wire logic ramp_done,
	input wire logic pwm_compare,
	input wire logic overcurrent_cmp,
	output logic high_drive,
	output logic low_drive,
	output logic [7:0] softstart_capacitor,
	output logic [7:0] reg_reference,
	output logic undervoltage_lockout,
	output logic hiccup_active,
	output logic [2:0] fault_count,
	output logic sync_locked
);

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic sync_prev_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 4'h0;
			sync_reg <= 4'h0;
		end else begin
			meta_reg <= {sync_in, osc_tick, ramp_done, overcurrent_cmp};
			sync_reg <= meta_reg;
		end
	end

	// Logic reads only the second stage; the first may still be settling.
	logic sync_s;
	logic osc_s;
	logic ramp_s;
	logic oc_s;
	assign {sync_s, osc_s, ramp_s, oc_s} = sync_reg;

	logic osc_prev_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_prev_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			sync_prev_reg <= sync_s;
			osc_prev_reg <= osc_s;
		end
	end

	// ---------------------------------------------------------------
	// Master clock selection
	// ---------------------------------------------------------------
	logic sync_fall;
	logic osc_rise;
	assign sync_fall = sync_prev_reg & ~sync_s;
	assign osc_rise = osc_s & ~osc_prev_reg;

	// A sync edge within the timeout keeps the external source in charge.
	// Without the timeout a stuck-low sync would freeze switching.
	logic [15:0] sync_age_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_age_reg <= 16'h0;
			sync_locked <= 1'b0;
		end else if (sync_fall) begin
			sync_age_reg <= 16'h0;
			sync_locked <= 1'b1;
		end else if (sync_age_reg >= 16'(SYNC_TIMEOUT)) begin
			sync_locked <= 1'b0;
		end else begin
			sync_age_reg <= sync_age_reg + 16'h1;
		end
	end

	logic cycle_start;
	assign cycle_start = sync_locked ? sync_fall : osc_rise;

	// ---------------------------------------------------------------
	// Ramp tracking per cycle
	// ---------------------------------------------------------------
	logic ramp_seen_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_seen_reg <= 1'b0;
		end else if (cycle_start) begin
			ramp_seen_reg <= 1'b0;
		end else if (ramp_s) begin
			ramp_seen_reg <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Undervoltage lockout
	// ---------------------------------------------------------------
	logic [2:0] uv_cnt_reg;
	// One counter serves both directions and restarts on each toggle, so a
	// single spike can never flip the lockout on its own.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			uv_cnt_reg <= boc_pkg::UV_RST;
			undervoltage_lockout <= 1'b1;
		end else if (cycle_start) begin
			if (undervoltage_lockout == ramp_seen_reg) begin
				if (uv_cnt_reg == boc_pkg::UV_TRIP - 3'h1) begin
					uv_cnt_reg <= boc_pkg::UV_RST;
					undervoltage_lockout <= ~ramp_seen_reg;
				end else begin
					uv_cnt_reg <= uv_cnt_reg + 3'h1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// State decode
	// ---------------------------------------------------------------
	function automatic logic in_state(input boc_pkg::boc_state_e now,
		input boc_pkg::boc_state_e want);
		return now == want;
	endfunction

	// ---------------------------------------------------------------
	// Hiccup restart
	// ---------------------------------------------------------------
	// The run ramp is part-charged or full when hiccup begins; without a restart
	// the first soft-start would be counted early and the off time cut short.
	logic hiccup_prev_reg;
	logic restart_now;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hiccup_prev_reg <= 1'b0;
		end else begin
			hiccup_prev_reg <= hiccup_active;
		end
	end
	assign restart_now = hiccup_active & ~hiccup_prev_reg;

	// ---------------------------------------------------------------
	// Soft-start ramp and reference
	// ---------------------------------------------------------------
	boc_pkg::boc_state_e state_reg;
	logic [7:0] ss_reg;
	logic [2:0] ss_cycles_reg;
	logic ss_full;
	assign ss_full = ss_reg == boc_pkg::SS_RAMP_STEPS;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ss_reg <= boc_pkg::SS_RAMP_RST;
		end else if (in_state(state_reg, boc_pkg::BOC_LOCKOUT)) begin
			ss_reg <= boc_pkg::SS_RAMP_RST;
		end else if (restart_now) begin
			// The restart discharges the ramp before the first soft-start.
			ss_reg <= boc_pkg::SS_RAMP_RST;
		end else if (cycle_start) begin
			if (!ss_full) begin
				ss_reg <= ss_reg + 8'h1;
			end else if (in_state(state_reg, boc_pkg::BOC_HICCUP)) begin
				ss_reg <= boc_pkg::SS_RAMP_RST;
			end
		end
	end
	assign softstart_capacitor = ss_reg;

	always_comb begin
		if (ss_reg <= boc_pkg::SS_OFFSET) begin
			reg_reference = 8'h00;
		end else if (ss_reg - boc_pkg::SS_OFFSET < boc_pkg::REF_LEVEL) begin
			reg_reference = ss_reg - boc_pkg::SS_OFFSET;
		end else begin
			reg_reference = boc_pkg::REF_LEVEL;
		end
	end

	// ---------------------------------------------------------------
	// Fault counter and hiccup control
	// ---------------------------------------------------------------
	// Overcurrent is only judged while the high side conducts, because
	// the sensed drop means nothing with the switch open.
	logic oc_cycle_reg;
	logic oc_now;
	assign oc_now = oc_s & high_drive;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_cycle_reg <= 1'b0;
		end else if (cycle_start) begin
			oc_cycle_reg <= 1'b0;
		end else if (oc_now) begin
			oc_cycle_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= boc_pkg::BOC_LOCKOUT;
			fault_count <= boc_pkg::FAULT_RST;
			ss_cycles_reg <= 3'h0;
		end else if (undervoltage_lockout) begin
			state_reg <= boc_pkg::BOC_LOCKOUT;
			fault_count <= boc_pkg::FAULT_RST;
		end else begin
			case (state_reg)
				boc_pkg::BOC_LOCKOUT: begin
					state_reg <= boc_pkg::BOC_RUN;
				end
				boc_pkg::BOC_RUN: begin
					if (cycle_start) begin
						if (oc_cycle_reg) begin
							if (fault_count == boc_pkg::FAULT_TRIP - 3'h1) begin
								fault_count <= boc_pkg::FAULT_TRIP;
								state_reg <= boc_pkg::BOC_HICCUP;
								ss_cycles_reg <= boc_pkg::SS_CYCLES;
							end else begin
								fault_count <= fault_count + 3'h1;
							end
						end else if (fault_count != 3'h0) begin
							fault_count <= fault_count - 3'h1;
						end
					end
				end
				boc_pkg::BOC_HICCUP: begin
					if (ss_full && cycle_start) begin
						ss_cycles_reg <= ss_cycles_reg - 3'h1;
						if (fault_count == 3'h1 || ss_cycles_reg == 3'h1) begin
							fault_count <= 3'h0;
							state_reg <= boc_pkg::BOC_RUN;
						end else begin
							fault_count <= fault_count - 3'h1;
						end
					end
				end
				default: begin
					state_reg <= boc_pkg::BOC_LOCKOUT;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Gate drive
	// ---------------------------------------------------------------
	// Drives are registered; the cut costs one cycle after the synchronised
	// comparator, which is the best a clocked block can do.
	boc_pkg::boc_drive_s drive_next;
	always_comb begin
		drive_next = '0;
		if (state_reg == boc_pkg::BOC_RUN && !undervoltage_lockout) begin
			drive_next.high_on = pwm_compare & ~oc_now & ~oc_cycle_reg
				& ~cycle_start;
			// Both drives rest at a cycle start, the only edge at which
			// hiccup or lockout can begin, so neither sees a live drive.
			drive_next.low_on = ~drive_next.high_on & ~high_drive
				& ~cycle_start;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_drive <= 1'b0;
			low_drive <= 1'b0;
		end else begin
			high_drive <= drive_next.high_on;
			low_drive <= drive_next.low_on;
		end
	end

	assign hiccup_active = state_reg == boc_pkg::BOC_HICCUP;

endmodule

// ===== verilog/boc_pkg.sv
package boc_pkg;

	// ---------------------------------------------------------------
	// Counts
	// ---------------------------------------------------------------
	localparam int FAULT_W = 3;
	localparam logic [2:0] FAULT_TRIP = 3'h7;
	localparam logic [2:0] FAULT_RST = 3'h0;
	localparam logic [2:0] UV_TRIP = 3'h7;
	localparam logic [2:0] UV_RST = 3'h0;
	localparam logic [2:0] SS_CYCLES = 3'h7;
	localparam int SS_CNT_W = 8;
	localparam logic [7:0] SS_RAMP_STEPS = 8'hff;
	localparam logic [7:0] SS_RAMP_RST = 8'h00;

	// ---------------------------------------------------------------
	// Soft-start offset and reference level, in steps of the soft-start ramp
	// ---------------------------------------------------------------
	localparam logic [7:0] SS_OFFSET = 8'h55;
	localparam logic [7:0] REF_LEVEL = 8'h46;

	typedef enum logic [1:0] {
		BOC_LOCKOUT,
		BOC_RUN,
		BOC_HICCUP
	} boc_state_e;

	typedef struct packed {
		logic high_on;
		logic low_on;
	} boc_drive_s;

endpackage
